// ---- hw/fws_host.sv ----
// Host controller that runs read, write, data-polling and toggle-polling cycles on a flash.
// Assumes flash inputs are synchronous to clk and the busy line has an external pull-up.
//
// Overview of operation
// - Host polls at the programmed address.
// - Host polls inside a sector being erased.
// - Host trusts full word only next read.
// - Host reads twice and compares toggle bit.
// - Stopped toggle means done; read data next (the host sets done on that compare and does no further read).
// - Toggle plus timeout: recheck, else reset command.
// - Host rechecks polling bit despite timeout.
// - Host ends with fail set after the reset command; it does not restart polling.
`timescale 1ns/1ps
module fws_host
    import fws_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_adr_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    output fws_pins_s              pins,
    input  wire logic [DATA_W-1:0] data_lines_in,
    input  wire logic              ready_busy_n_in
);
    fws_state_e        state_reg;
    fws_op_e           op_reg;
    fws_pins_s         pins_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [3:0]        cnt_reg;
    logic              busy_reg;
    logic              done_reg;
    logic              fail_reg;
    logic              tmo_reg;
    logic              first_reg;
    logic              rechk_reg;
    logic              final_reg;
    logic              tb_prev_reg;
    logic              ack_reg;
    logic [31:0]       dat_reg;
    logic              wb_req;
    logic              go;

    assign wb_req   = wb_cyc_i && wb_stb_i && !ack_reg;
    assign go       = wb_req && wb_we_i && wb_sel_i[1] && (wb_adr_i[3:0] == REG_CTRL)
                      && wb_dat_i[CTRL_GO] && !busy_reg;
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign pins     = pins_reg;

    // Every access is answered one cycle after it is seen; unmapped words read zero.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end else begin
            ack_reg <= wb_req;
            dat_reg <= 32'h00000000;
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i[3:0])
                    REG_CTRL:  dat_reg <= {30'h00000000, op_reg};
                    REG_ADDR:  dat_reg <= 32'(addr_reg);
                    REG_WDATA: dat_reg <= 32'(wdata_reg);
                    REG_STAT: begin
                        dat_reg[ST_BUSY]                 <= busy_reg;
                        dat_reg[ST_DONE]                 <= done_reg;
                        dat_reg[ST_FAIL]                 <= fail_reg;
                        dat_reg[ST_RB]                   <= ready_busy_n_in;
                        dat_reg[ST_TMO]                  <= tmo_reg;
                        dat_reg[ST_TB2]                  <= rdata_reg[TB2_BIT];
                        dat_reg[ST_ERT]                  <= rdata_reg[ERT_BIT];
                        dat_reg[ST_DATA +: DATA_W]       <= rdata_reg;
                    end
                    default:   dat_reg <= 32'h00000000;
                endcase
            end
        end
    end

    // Address and data may only change while the controller is idle.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            addr_reg  <= '0;
            wdata_reg <= '0;
            op_reg    <= OP_READ;
        end else if (wb_req && wb_we_i && !busy_reg) begin
            if (wb_adr_i[3:0] == REG_ADDR)
                addr_reg <= wb_dat_i[ADDR_W-1:0];
            if (wb_adr_i[3:0] == REG_WDATA)
                wdata_reg <= wb_dat_i[DATA_W-1:0];
            if (wb_adr_i[3:0] == REG_CTRL && wb_sel_i[0])
                op_reg <= fws_op_e'(wb_dat_i[1:0]);
        end
    end

    // Sequencer: read and write cycles on the pins plus the two polling procedures.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg   <= S_IDLE;
            pins_reg    <= '{addr: '0, dq_out: '0, dq_oe_n: 1'b1, ce_n: 1'b1,
                             oe_n: 1'b1, we_n: 1'b1};
            rdata_reg   <= '0;
            cnt_reg     <= 4'h0;
            busy_reg    <= 1'b0;
            done_reg    <= 1'b0;
            fail_reg    <= 1'b0;
            tmo_reg     <= 1'b0;
            first_reg   <= 1'b0;
            rechk_reg   <= 1'b0;
            final_reg   <= 1'b0;
            tb_prev_reg <= 1'b0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (go) begin
                        busy_reg      <= 1'b1;
                        done_reg      <= 1'b0;
                        fail_reg      <= 1'b0;
                        tmo_reg       <= 1'b0;
                        first_reg     <= 1'b1;
                        rechk_reg     <= 1'b0;
                        final_reg     <= 1'b0;
                        cnt_reg       <= 4'h1;
                        pins_reg.addr <= addr_reg;
                        pins_reg.ce_n <= 1'b0;
                        if (fws_op_e'(wb_dat_i[1:0]) == OP_WRITE) begin
                            pins_reg.dq_out  <= wdata_reg;
                            pins_reg.dq_oe_n <= 1'b0;
                            pins_reg.we_n    <= 1'b0;
                            state_reg        <= S_WR;
                        end else begin
                            pins_reg.oe_n <= 1'b0;
                            state_reg     <= S_RD;
                        end
                    end
                end
                S_RD: begin
                    if (cnt_reg >= ACC_CYC) begin
                        rdata_reg     <= data_lines_in;
                        pins_reg.ce_n <= 1'b1;
                        pins_reg.oe_n <= 1'b1;
                        state_reg     <= S_RHI;
                    end else begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end
                S_RHI: state_reg <= S_EVAL;
                S_EVAL: begin
                    cnt_reg       <= 4'h1;
                    pins_reg.ce_n <= 1'b0;
                    pins_reg.oe_n <= 1'b0;
                    state_reg     <= S_RD;
                    first_reg     <= 1'b0;
                    if (rdata_reg[TMO_BIT] && op_reg != OP_READ)
                        tmo_reg <= 1'b1;
                    case (op_reg)
                        OP_DPOLL: begin
                            // A mismatch between two matching reads restarts the count.
                            final_reg <= 1'b0;
                            if (rdata_reg[DP_BIT] == wdata_reg[DP_BIT]) begin
                                // The first matching read may carry stale upper lines.
                                if (final_reg) begin
                                    pins_reg.ce_n <= 1'b1;
                                    pins_reg.oe_n <= 1'b1;
                                    busy_reg      <= 1'b0;
                                    done_reg      <= 1'b1;
                                    state_reg     <= S_IDLE;
                                end
                                final_reg <= 1'b1;
                            end else if (rechk_reg) begin
                                pins_reg.oe_n    <= 1'b1;
                                pins_reg.we_n    <= 1'b0;
                                pins_reg.dq_out  <= RESET_CMD;
                                pins_reg.dq_oe_n <= 1'b0;
                                fail_reg         <= 1'b1;
                                state_reg        <= S_WR;
                            end else if (rdata_reg[TMO_BIT]) begin
                                rechk_reg <= 1'b1;
                            end
                        end
                        OP_TPOLL: begin
                            tb_prev_reg <= rdata_reg[TB1_BIT];
                            if (first_reg) begin
                                first_reg <= 1'b0;
                            end else if (rdata_reg[TB1_BIT] == tb_prev_reg) begin
                                pins_reg.ce_n <= 1'b1;
                                pins_reg.oe_n <= 1'b1;
                                busy_reg      <= 1'b0;
                                done_reg      <= 1'b1;
                                state_reg     <= S_IDLE;
                            end else if (rechk_reg) begin
                                pins_reg.oe_n    <= 1'b1;
                                pins_reg.we_n    <= 1'b0;
                                pins_reg.dq_out  <= RESET_CMD;
                                pins_reg.dq_oe_n <= 1'b0;
                                fail_reg         <= 1'b1;
                                state_reg        <= S_WR;
                            end else if (rdata_reg[TMO_BIT]) begin
                                rechk_reg <= 1'b1;
                            end
                        end
                        default: begin
                            pins_reg.ce_n <= 1'b1;
                            pins_reg.oe_n <= 1'b1;
                            busy_reg      <= 1'b0;
                            done_reg      <= 1'b1;
                            state_reg     <= S_IDLE;
                        end
                    endcase
                end
                S_WR: begin
                    if (cnt_reg >= WP_CYC) begin
                        pins_reg.we_n <= 1'b1;
                        pins_reg.ce_n <= 1'b1;
                        state_reg     <= S_WHI;
                    end else begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end
                S_WHI: begin
                    pins_reg.dq_oe_n <= 1'b1;
                    busy_reg         <= 1'b0;
                    done_reg         <= 1'b1;
                    state_reg        <= S_IDLE;
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    chk_strobe_excl: assert property (@(posedge clk) disable iff (!resetn)
        !(!pins_reg.oe_n && !pins_reg.we_n)) else $error("oe and we low together");
    chk_oe_with_ce: assert property (@(posedge clk) disable iff (!resetn)
        !pins_reg.oe_n |-> !pins_reg.ce_n) else $error("oe low without ce");
    chk_no_drive_read: assert property (@(posedge clk) disable iff (!resetn)
        !pins_reg.oe_n |-> pins_reg.dq_oe_n) else $error("driving data during a read");
    chk_read_length: assert property (@(posedge clk) disable iff (!resetn)
        $fell(pins_reg.oe_n) |-> !pins_reg.oe_n[*2] ##1 pins_reg.oe_n)
        else $error("read strobe length wrong");
    chk_addr_stable: assert property (@(posedge clk) disable iff (!resetn)
        (busy_reg && $past(busy_reg)) |-> $stable(pins_reg.addr))
        else $error("address moved during operation");
    chk_fail_reset: assert property (@(posedge clk) disable iff (!resetn)
        $rose(fail_reg) |-> !pins_reg.we_n && pins_reg.dq_out == RESET_CMD)
        else $error("failure without reset command");
    chk_tpoll_done: assert property (@(posedge clk) disable iff (!resetn)
        ($rose(done_reg) && op_reg == OP_TPOLL && !fail_reg)
        |-> rdata_reg[TB1_BIT] == $past(tb_prev_reg)) else $error("done while toggling");
    chk_dpoll_done: assert property (@(posedge clk) disable iff (!resetn)
        ($rose(done_reg) && op_reg == OP_DPOLL && !fail_reg)
        |-> $past(final_reg) && rdata_reg[DP_BIT] == wdata_reg[DP_BIT])
        else $error("data poll ended early");
    chk_ack_pulse: assert property (@(posedge clk) disable iff (!resetn)
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    chk_write_end: assert property (@(posedge clk) disable iff (!resetn)
        $rose(pins_reg.we_n) |=> !busy_reg && pins_reg.dq_oe_n)
        else $error("write cycle did not finish");

    cov_tpoll_ok: cover property (@(posedge clk) disable iff (!resetn)
        $rose(done_reg) && op_reg == OP_TPOLL && !fail_reg);
    cov_dpoll_ok: cover property (@(posedge clk) disable iff (!resetn)
        $rose(done_reg) && op_reg == OP_DPOLL && !fail_reg);
    cov_fail: cover property (@(posedge clk) disable iff (!resetn) $rose(fail_reg));
    cov_write: cover property (@(posedge clk) disable iff (!resetn)
        $rose(done_reg) && op_reg == OP_WRITE);
endmodule // fws_host

// ---- hw/fws_pkg.sv ----
// Constants, register map and pin bundle of the flash status-polling host.
// Assumes a 25 MHz system clock and a word-wide flash with asynchronous strobes.
package fws_pkg;
    localparam int          ADDR_W     = 22;
    localparam int          DATA_W     = 16;
    localparam int          CLK_NS     = 40;
    localparam int          T_ACC_NS   = 70;
    localparam int          T_WP_NS    = 35;
    localparam logic [3:0]  ACC_CYC    = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0]  WP_CYC     = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] RESET_CMD  = 16'h00F0;
    localparam int          DP_BIT     = 7;
    localparam int          TB1_BIT    = 6;
    localparam int          TMO_BIT    = 5;
    localparam int          TB2_BIT    = 2;
    localparam int          ERT_BIT    = 3;
    // Wishbone byte addresses of the controller's own registers.
    localparam logic [3:0]  REG_CTRL   = 4'h0;
    localparam logic [3:0]  REG_ADDR   = 4'h4;
    localparam logic [3:0]  REG_WDATA  = 4'h8;
    localparam logic [3:0]  REG_STAT   = 4'hC;
    localparam int          CTRL_GO    = 8;
    localparam int          ST_BUSY    = 0;
    localparam int          ST_DONE    = 1;
    localparam int          ST_FAIL    = 2;
    localparam int          ST_RB      = 3;
    localparam int          ST_TMO     = 4;
    localparam int          ST_TB2     = 5;
    localparam int          ST_ERT     = 6;
    localparam int          ST_DATA    = 16;

    typedef enum logic [1:0] {
        OP_READ   = 2'h0,
        OP_WRITE  = 2'h1,
        OP_DPOLL  = 2'h2,
        OP_TPOLL  = 2'h3
    } fws_op_e;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_RD   = 6'h02,
        S_RHI  = 6'h04,
        S_EVAL = 6'h08,
        S_WR   = 6'h10,
        S_WHI  = 6'h20
    } fws_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic              dq_oe_n;
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
    } fws_pins_s;
endpackage

// ---- test/fws_flash_model.sv ----
// Behavioural flash that answers status reads from the host's registered pins.
// Assumes the bench starts and ends embedded operations through the start task below.
`timescale 1ns/1ps
module fws_flash_model
    import fws_pkg::*;
(
    input  wire logic         clk,
    input  fws_pins_s         pins,
    output logic [DATA_W-1:0] data_lines,
    output logic              rb_oe_n
);
    logic [1:0]        mode    = 2'h0;
    logic [ADDR_W-1:0] op_addr = '0;
    logic [ADDR_W-1:0] mem_a   = '1;
    logic [ADDR_W-1:0] wr_addr = '0;
    logic [DATA_W-1:0] op_data = '0;
    logic [DATA_W-1:0] mem_d   = '0;
    logic [DATA_W-1:0] wr_data = '0;
    logic [DATA_W-1:0] last    = '0;
    logic [9:0]        prot_sec = 10'h3FF;
    logic [DATA_W-1:0] stat;
    logic [DATA_W-1:0] arr;
    logic              tog     = 1'b0;
    logic              tog2    = 1'b0;
    logic              tmo     = 1'b0;
    logic              erased  = 1'b0;
    logic              rd_prev = 1'b0;
    logic              we_prev = 1'b1;
    logic              rd;
    int                left    = 0;

    // Mode 1 program, 2 erase, 3 suspended erase; status is live from the call on.
    task automatic start(input logic [1:0] m, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d, input int n, input logic t);
        mode = m;
        op_addr = a;
        op_data = d;
        left = n;
        tmo = t;
    endtask

    assign rd = !pins.ce_n && !pins.oe_n;
    // An erase skips the protected sector, so it keeps its old contents.
    assign arr = (pins.addr == mem_a) ? mem_d :
                 ((erased && pins.addr[21:12] != prot_sec) ? 16'hFFFF :
                  pins.addr[15:0] ^ 16'hA5A5);
    assign rb_oe_n = !(mode == 2'h1 || mode == 2'h2);

    always_comb begin
        stat = '0;
        stat[TMO_BIT] = tmo;
        stat[TB1_BIT] = tog;
        if (mode == 2'h1) begin
            stat[15:8] = ~op_data[15:8];
            stat[DP_BIT] = ~op_data[7];
        end else begin
            stat[DP_BIT] = (mode == 2'h3);
            stat[ERT_BIT] = 1'b1;
            stat[TB2_BIT] = tog2;
        end
        // A released bus shows the inverse of its last level, never a stale copy.
        if (rd && mode != 2'h0 && pins.addr[21:19] == op_addr[21:19]) begin
            data_lines = stat;
        end else if (rd) begin
            data_lines = arr;
        end else if (!pins.dq_oe_n) begin
            data_lines = pins.dq_out;
        end else begin
            data_lines = ~last;
        end
    end

    always @(posedge clk) begin
        last <= data_lines;
        rd_prev <= rd;
        we_prev <= pins.we_n;
        if (rd_prev && !rd && mode != 2'h0) begin
            tog2 <= ~tog2;
            if (mode != 2'h3) begin
                tog <= ~tog;
            end
            if (mode != 2'h3 && !tmo) begin
                left <= left - 1;
                if (left <= 1) begin
                    mode <= 2'h0;
                    erased <= erased | (mode == 2'h2);
                    mem_a <= (mode == 2'h1) ? op_addr : mem_a;
                    mem_d <= (mode == 2'h1) ? op_data : mem_d;
                end
            end
        end
        if (!we_prev && pins.we_n) begin
            wr_addr <= pins.addr;
            wr_data <= pins.dq_out;
            if (pins.dq_out == RESET_CMD) begin
                mode <= 2'h0;
                tmo <= 1'b0;
            end
        end
    end
endmodule // fws_flash_model

// ---- test/fws_host_tb.sv ----
// Self-checking bench for the flash status-polling host over Wishbone.
// Assumes the behavioural flash model stands on the far side of the pins.
`timescale 1ns/1ps
module fws_host_tb
    import fws_pkg::*;
;
    logic              clk;
    logic              resetn;
    logic              cyc;
    logic              stb;
    logic              we;
    logic              ack;
    logic              rb_oe_n;
    logic              rb_level;
    logic [31:0]       adr;
    logic [31:0]       wdat;
    logic [31:0]       rdat;
    logic [31:0]       st;
    logic [DATA_W-1:0] dl;
    fws_pins_s         pins;
    int                failures = 0;
    int                n_tests = 0;

    assign rb_level = rb_oe_n ? 1'b1 : 1'b0;

    fws_host uut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_sel_i(4'hF), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pins(pins), .data_lines_in(dl), .ready_busy_n_in(rb_level));
    fws_flash_model flash (.clk(clk), .pins(pins), .data_lines(dl), .rb_oe_n(rb_oe_n));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int i;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (ack === 1'b1) break;
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (i == 20) begin
            failures++;
            stop_test();
        end
    endtask

    // Starts one host operation and polls the status register until busy clears.
    task automatic run(input logic [1:0] op, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] s);
        int i;
        logic [31:0] q;
        wb(1'b1, 32'(REG_ADDR), a, q);
        wb(1'b1, 32'(REG_WDATA), d, q);
        wb(1'b1, 32'(REG_CTRL), {24'h000001, 6'h00, op}, q);
        for (i = 0; i < 300; i++) begin
            wb(1'b0, 32'(REG_STAT), 32'h0, s);
            if (s[ST_BUSY] === 1'b0) break;
        end
        if (i == 300) begin
            failures++;
            stop_test();
        end
    endtask

    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 32'h0;
        wdat = 32'h0;
        resetn = 1'b0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        wb(1'b0, 32'h00000002, 32'h0, st);
        chk(st, 32'h0);
        run(OP_READ, 32'h00000123, 32'h0, st);
        chk(st & 32'hFFFF0007, 32'hA4860002);
        $display("plain read done");
        @(negedge clk);
        flash.start(2'h1, 22'h0A0040, 16'h12B4, 6, 1'b0);
        wb(1'b0, 32'(REG_STAT), 32'h0, st);
        chk(32'(st[ST_RB]), 32'h0);
        run(OP_DPOLL, 32'h000A0040, 32'h000012B4, st);
        chk(st & 32'hFFFF000F, 32'h12B4000A);
        $display("program data poll done");
        @(negedge clk);
        flash.start(2'h2, 22'h100000, 16'h0, 6, 1'b0);
        run(OP_TPOLL, 32'h00100000, 32'h0, st);
        chk(st & 32'h7, 32'h2);
        @(negedge clk);
        flash.start(2'h2, 22'h100000, 16'h0, 5, 1'b0);
        run(OP_DPOLL, 32'h00100000, 32'h00000080, st);
        chk(st & 32'hFFFF0007, 32'hFFFF0002);
        $display("erase polls done");
        @(negedge clk);
        flash.start(2'h3, 22'h100000, 16'h0, 1, 1'b0);
        run(OP_TPOLL, 32'h00100000, 32'h0, st);
        chk(st & 32'h0088004F, 32'h0088004A);
        @(negedge clk);
        flash.start(2'h2, 22'h200000, 16'h0, 1000, 1'b0);
        run(OP_READ, 32'h00000123, 32'h0, st);
        chk(st & 32'hFFFF0007, 32'hFFFF0002);
        run(OP_READ, 32'h003FF123, 32'h0, st);
        chk(st & 32'hFFFF0007, 32'h54860002);
        @(negedge clk);
        flash.start(2'h0, 22'h0, 16'h0, 0, 1'b0);
        $display("suspend and bank tests done");
        run(OP_WRITE, 32'h00000555, 32'h000000AA, st);
        chk(st & 32'h7, 32'h2);
        chk({16'h0, flash.wr_data}, 32'h000000AA);
        chk({10'h0, flash.wr_addr}, 32'h00000555);
        $display("write cycle done");
        @(negedge clk);
        flash.start(2'h1, 22'h0A0080, 16'h00FF, 1000, 1'b1);
        run(OP_TPOLL, 32'h000A0080, 32'h0, st);
        chk(st & 32'h17, 32'h16);
        chk({16'h0, flash.wr_data}, 32'(RESET_CMD));
        chk({10'h0, flash.wr_addr}, 32'h000A0080);
        $display("timeout test done");
        @(negedge clk);
        flash.start(2'h1, 22'h0A00C0, 16'h00FF, 1000, 1'b1);
        run(OP_DPOLL, 32'h000A00C0, 32'h000000FF, st);
        chk(st & 32'h17, 32'h16);
        chk({16'h0, flash.wr_data}, 32'(RESET_CMD));
        chk({10'h0, flash.wr_addr}, 32'h000A00C0);
        $display("data poll timeout test done");
        stop_test();
    end
endmodule // fws_host_tb
